// file: logic/sbc_defs.svh
// Purpose: constants for the restart / fail-safe mode controller
// Assumes: 100 MHz clock, one file of logic
// Notes: reset delay choices are plain defaults
// Behaviour
// - reset output low throughout restart
// - restart ends in normal, autonomously, unless a fail-safe cause enters fail-safe first
// - reset released at exit after programmed delay
// - entry cause latched until software reads it
// - sleep wake reported in bits, no interrupt
// - restart never clears an active limp-home
// - first response after normal holds restart cause
// - init time-out: restart, limp-home on, limp reason
// - supply undervoltage or watchdog failure causes restart
// - external reset low: restart, restart reason
// - clamped reset: config 1/3 restart, 2/4 fail-safe
// - config 2 watchdog failure goes to fail-safe
// - config 4: first restart, second fail-safe
// - flash-mode restart keeps limp-home, restart reason
// - sleep wake: restart, supply ramps up
// - fail-safe: regulators off, limp-home on
// - supply time-out or overtemperature enters fail-safe
// - overtemperature latch holds until cooled, wakes ignored
// - fail-safe wake: restart, store wake, clear counter
// - first response after normal holds fail-safe cause
// - grounded test pin selects development mode
// - development mode: watchdog failure only interrupts
// - development mode keeps all other entry causes
// - config 1 first watchdog miss: restart, limp-home
// - init time-out 256 ms after reset release
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH
`define SBC_CLK_MHZ 100
`define SBC_INIT_TMO_MS 256
`define SBC_INIT_TMO_CYC (`SBC_INIT_TMO_MS * 1000 * `SBC_CLK_MHZ)
`define SBC_RD_SHORT_US 2
`define SBC_RD_LONG_US 10
`define SBC_RD_SHORT_CYC (`SBC_RD_SHORT_US * `SBC_CLK_MHZ)
`define SBC_RD_LONG_CYC (`SBC_RD_LONG_US * `SBC_CLK_MHZ)
`define SBC_LR_NONE 3'h0
`define SBC_LR_INIT_TMO 3'h1
`define SBC_LR_CLAMP 3'h2
`define SBC_LR_WDOG 3'h3
`define SBC_LR_FS_WAKE 3'h4
`define SBC_RR_NONE 2'h0
`define SBC_RR_EXT 2'h1
`define SBC_RR_UV 2'h2
`define SBC_RR_WDOG_SPI 2'h3
`define SBC_CFG_DEV 3'h0
`define SBC_CFG_1 3'h1
`define SBC_CFG_2 3'h2
`define SBC_CFG_3 3'h3
`define SBC_CFG_4 3'h4
`endif

// file: logic/sbc_pkg.sv
// Purpose: types for the restart / fail-safe mode controller
// Assumes: used with sbc_defs.svh
// Notes: none
package sbc_pkg;
    // gray codes along init, normal, restart, fail-safe
    typedef enum logic [2:0] {
        SBC_INIT = 3'h0,
        SBC_NORMAL = 3'h1,
        SBC_RESTART = 3'h3,
        SBC_FAILSAFE = 3'h2,
        SBC_STOP = 3'h6,
        SBC_SLEEP = 3'h7,
        SBC_FLASH = 3'h5
    } sbc_mode_e;
    typedef struct packed {
        logic ext_reset_low;
        logic reset_clamped;
        logic mcu_uv;
        logic mcu_uv_timeout;
        logic vs_above_lhuv;
        logic mcu_overtemp;
        logic mcu_cooled;
        logic wdog_fail;
        logic wake;
    } sbc_event_s;
    typedef struct packed {
        logic go_normal;
        logic go_stop;
        logic go_sleep;
        logic go_flash;
        logic go_restart;
        logic limp_on;
        logic limp_off;
        logic valid;
    } sbc_cmd_s;
    typedef struct packed {
        logic [2:0] limp_reason_bits;
        logic [1:0] restart_reason_bits;
        logic [3:0] wake_source_bits;
        logic from_failsafe;
    } sbc_status_s;
endpackage

// file: logic/sbc_mode_ctrl.sv
// Purpose: mode control for restart, fail-safe and development modes
// Assumes: inputs synchronous to clk; strobes are one-cycle pulses
// Notes: status clears on status_read pulse
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defs.svh"
module sbc_mode_ctrl #(
    parameter int unsigned INIT_TMO_CYC = `SBC_INIT_TMO_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic test_pin_low,
    input wire logic [2:0] fs_config,
    input wire logic reset_delay_sel,
    input wire sbc_pkg::sbc_event_s ev,
    input wire sbc_pkg::sbc_cmd_s cmd,
    input wire logic [3:0] wake_src,
    input wire logic status_read,
    output logic mcu_reset_output_n,
    output logic limp_home_output,
    output logic mcu_supply_en,
    output logic regulators_en,
    output logic xcvr_wake_capable,
    output logic wdog_int,
    output logic dev_mode,
    output var sbc_pkg::sbc_mode_e mode,
    output var sbc_pkg::sbc_status_s status
);
    sbc_pkg::sbc_mode_e mode_reg, mode_next;
    logic [31:0] tmr_reg;
    logic [1:0] wdfail_cnt_reg;
    logic limp_reg, limp_next;
    logic ot_latch_reg;
    logic dev_reg;
    logic strap_done_reg;
    logic [2:0] lr_reg, lr_next;
    logic [1:0] rr_reg, rr_next;
    logic [3:0] wk_reg;
    logic fs_flag_reg;
    logic int_reg;

    // entry decoding
    wire logic [2:0] cfg = fs_config;
    wire logic cfg13 = (cfg == `SBC_CFG_1) || (cfg == `SBC_CFG_3);
    wire logic cfg24 = (cfg == `SBC_CFG_2) || (cfg == `SBC_CFG_4);
    wire logic in_init = (mode_reg == sbc_pkg::SBC_INIT);
    wire logic in_rst = (mode_reg == sbc_pkg::SBC_RESTART);
    wire logic in_fs = (mode_reg == sbc_pkg::SBC_FAILSAFE);
    wire logic in_sleep = (mode_reg == sbc_pkg::SBC_SLEEP);
    wire logic in_flash = (mode_reg == sbc_pkg::SBC_FLASH);
    wire logic run_mode = (mode_reg == sbc_pkg::SBC_NORMAL) || (mode_reg == sbc_pkg::SBC_STOP) || in_flash;
    wire logic wd_ev = ev.wdog_fail && run_mode && !dev_reg;
    wire logic wd_first = (wdfail_cnt_reg == 2'h0);
    // config 2 direct, config 4 on second consecutive failure
    wire logic wd_to_fs = wd_ev && !in_flash && ((cfg == `SBC_CFG_2) || ((cfg == `SBC_CFG_4) && !wd_first));
    wire logic wd_to_rs = wd_ev && !wd_to_fs;
    wire logic wd_limp = !in_flash && ((cfg == `SBC_CFG_1) || ((cfg == `SBC_CFG_3) && !wd_first));
    wire logic fs_supply = !in_fs && ((ev.mcu_uv_timeout && ev.vs_above_lhuv) || ev.mcu_overtemp);
    wire logic clamp_fs = ev.reset_clamped && cfg24 && !in_fs && !in_sleep;
    wire logic clamp_rs = ev.reset_clamped && cfg13 && !in_fs && !in_sleep && !in_rst;
    wire logic go_fs = fs_supply || clamp_fs || wd_to_fs;
    wire logic init_tmo = in_init && strap_done_reg && (tmr_reg >= INIT_TMO_CYC) && !cmd.valid;
    wire logic ext_rs = ev.ext_reset_low && !in_rst && !in_fs;
    wire logic uv_rs = ev.mcu_uv && (run_mode || in_sleep);
    wire logic flash_rs = in_flash && cmd.go_restart;
    wire logic wake_rs = ev.wake && in_sleep;
    wire logic fs_exit = in_fs && ((ot_latch_reg && ev.mcu_cooled) || (!ot_latch_reg && ev.wake));
    wire logic [31:0] rd_cyc = reset_delay_sel ? 32'(`SBC_RD_LONG_CYC) : 32'(`SBC_RD_SHORT_CYC);
    wire logic rd_done = in_rst && (tmr_reg >= rd_cyc - 32'h1);

    // next mode, limp-home and cause selection
    always_comb begin
        mode_next = mode_reg;
        limp_next = limp_reg;
        // a read clears the causes unless a new cause is written below
        lr_next = status_read ? `SBC_LR_NONE : lr_reg;
        rr_next = status_read ? `SBC_RR_NONE : rr_reg;
        if (go_fs) begin
            mode_next = sbc_pkg::SBC_FAILSAFE;
            limp_next = 1'b1;
        end else if (fs_exit) begin
            mode_next = sbc_pkg::SBC_RESTART;
            lr_next = `SBC_LR_FS_WAKE;
        end else if (init_tmo) begin
            mode_next = sbc_pkg::SBC_RESTART;
            limp_next = 1'b1;
            lr_next = `SBC_LR_INIT_TMO;
        end else if (clamp_rs) begin
            mode_next = sbc_pkg::SBC_RESTART;
            limp_next = 1'b1;
            lr_next = `SBC_LR_CLAMP;
        end else if (ext_rs) begin
            mode_next = sbc_pkg::SBC_RESTART;
            rr_next = `SBC_RR_EXT;
        end else if (uv_rs) begin
            mode_next = sbc_pkg::SBC_RESTART;
            rr_next = `SBC_RR_UV;
        end else if (wd_to_rs) begin
            mode_next = sbc_pkg::SBC_RESTART;
            if (wd_limp) begin
                limp_next = 1'b1;
                lr_next = `SBC_LR_WDOG;
            end else begin
                rr_next = `SBC_RR_WDOG_SPI;
            end
        end else if (flash_rs) begin
            mode_next = sbc_pkg::SBC_RESTART;
            rr_next = `SBC_RR_WDOG_SPI;
        end else if (wake_rs) begin
            mode_next = sbc_pkg::SBC_RESTART;
        end else if (rd_done) begin
            mode_next = sbc_pkg::SBC_NORMAL;
        end else if (in_init && cmd.valid) begin
            if (cmd.go_normal) begin
                mode_next = sbc_pkg::SBC_NORMAL;
            end else if (cmd.go_flash) begin
                mode_next = sbc_pkg::SBC_FLASH;
            end
        end else if (mode_reg == sbc_pkg::SBC_NORMAL && cmd.valid) begin
            if (cmd.go_sleep) begin
                mode_next = sbc_pkg::SBC_SLEEP;
            end else if (cmd.go_stop) begin
                mode_next = sbc_pkg::SBC_STOP;
            end else if (cmd.go_flash) begin
                mode_next = sbc_pkg::SBC_FLASH;
            end
        end else if (mode_reg == sbc_pkg::SBC_STOP && cmd.valid && cmd.go_normal) begin
            mode_next = sbc_pkg::SBC_NORMAL;
        end
        if (cmd.valid && (run_mode) && !go_fs) begin
            if (cmd.limp_on) begin
                limp_next = 1'b1;
            end else if (cmd.limp_off) begin
                limp_next = 1'b0;
            end
        end
    end

    // mode register and timer; timer restarts on every mode change
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= sbc_pkg::SBC_INIT;
            tmr_reg <= 32'h0;
        end else if (ce) begin
            mode_reg <= mode_next;
            tmr_reg <= (mode_next != mode_reg) ? 32'h0 : tmr_reg + 32'h1;
        end
    end

    // limp-home, overtemperature latch and test strap
    always_ff @(posedge clk) begin
        if (rst) begin
            limp_reg <= 1'b0;
            ot_latch_reg <= 1'b0;
            dev_reg <= 1'b0;
            strap_done_reg <= 1'b0;
        end else if (ce) begin
            limp_reg <= limp_next;
            if (ev.mcu_overtemp) begin
                ot_latch_reg <= 1'b1;
            end else if (in_fs && ev.mcu_cooled) begin
                ot_latch_reg <= 1'b0;
            end
            if (!strap_done_reg) begin
                dev_reg <= test_pin_low;
                strap_done_reg <= 1'b1;
            end
        end
    end

    // consecutive watchdog failure counter
    always_ff @(posedge clk) begin
        if (rst) begin
            wdfail_cnt_reg <= 2'h0;
        end else if (ce) begin
            if (fs_exit) begin
                wdfail_cnt_reg <= 2'h0;
            end else if (wd_ev && wdfail_cnt_reg != 2'h3) begin
                wdfail_cnt_reg <= wdfail_cnt_reg + 2'h1;
            end
        end
    end

    // cause latches: new cause wins over a read in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            lr_reg <= `SBC_LR_NONE;
            rr_reg <= `SBC_RR_NONE;
            wk_reg <= 4'h0;
            fs_flag_reg <= 1'b0;
        end else if (ce) begin
            lr_reg <= lr_next;
            rr_reg <= rr_next;
            if (wake_rs || fs_exit) begin
                wk_reg <= wk_reg | wake_src;
            end else if (status_read) begin
                wk_reg <= 4'h0;
            end
            if (go_fs) begin
                fs_flag_reg <= 1'b1;
            end else if (status_read) begin
                fs_flag_reg <= 1'b0;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            mcu_reset_output_n <= 1'b0;
            limp_home_output <= 1'b0;
            mcu_supply_en <= 1'b0;
            regulators_en <= 1'b0;
            xcvr_wake_capable <= 1'b0;
            int_reg <= 1'b0;
            dev_mode <= 1'b0;
            mode <= sbc_pkg::SBC_INIT;
            status <= '0;
        end else if (ce) begin
            mcu_reset_output_n <= (mode_next != sbc_pkg::SBC_RESTART) && (mode_next != sbc_pkg::SBC_FAILSAFE);
            limp_home_output <= limp_next;
            mcu_supply_en <= (mode_next != sbc_pkg::SBC_FAILSAFE) && (mode_next != sbc_pkg::SBC_SLEEP);
            regulators_en <= (mode_next != sbc_pkg::SBC_FAILSAFE) && (mode_next != sbc_pkg::SBC_SLEEP);
            xcvr_wake_capable <= (mode_next == sbc_pkg::SBC_FAILSAFE) || (mode_next == sbc_pkg::SBC_SLEEP);
            int_reg <= ev.wdog_fail && run_mode && dev_reg;
            dev_mode <= dev_reg;
            mode <= mode_next;
            status <= '{limp_reason_bits: lr_reg, restart_reason_bits: rr_reg,
                        wake_source_bits: wk_reg, from_failsafe: fs_flag_reg};
        end
    end
    assign wdog_int = int_reg;
endmodule
`default_nettype wire

// file: tb/sbc_mode_checker.sv
// Purpose: port assertions for the mode controller
// Assumes: single clock, synchronous reset
// Notes: bound to every sbc_mode_ctrl below
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defs.svh"
module sbc_mode_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [2:0] fs_config,
    input wire sbc_pkg::sbc_event_s ev,
    input wire logic mcu_reset_output_n,
    input wire logic limp_home_output,
    input wire logic mcu_supply_en,
    input wire logic regulators_en,
    input wire logic xcvr_wake_capable,
    input wire logic wdog_int,
    input wire logic dev_mode,
    input wire sbc_pkg::sbc_mode_e mode
);
    localparam sbc_pkg::sbc_mode_e m_nm = sbc_pkg::SBC_NORMAL;
    localparam sbc_pkg::sbc_mode_e m_rs = sbc_pkg::SBC_RESTART;
    localparam sbc_pkg::sbc_mode_e m_fs = sbc_pkg::SBC_FAILSAFE;
    wire logic quiet;
    // enabled edge with no clamp, undervoltage, supply time-out or overtemperature event pending
    assign quiet = ce && !ev.reset_clamped && !ev.mcu_uv && !ev.mcu_uv_timeout && !ev.mcu_overtemp;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    hold_reset_a: assert property (mode == m_rs |-> !mcu_reset_output_n)
        else $error("reset output released in restart");
    exit_normal_a: assert property (mode == m_rs ##1 mode != m_rs |-> mode == m_nm)
        else $error("restart left for a mode other than normal");
    release_reset_a: assert property (mode == m_rs ##1 mode == m_nm |-> mcu_reset_output_n)
        else $error("reset output still low after restart exit");
    limp_kept_a: assert property (limp_home_output && mode == m_rs |=> limp_home_output)
        else $error("limp-home dropped around restart");
    ext_restart_a: assert property (quiet && ev.ext_reset_low && mode == m_nm
        |=> mode == m_rs && $stable(limp_home_output))
        else $error("outside reset did not restart cleanly");
    dev_wdog_a: assert property (quiet && !ev.ext_reset_low && ev.wdog_fail && dev_mode && mode == m_nm
        |=> wdog_int && mode != m_rs && mode != m_fs && mcu_supply_en)
        else $error("development watchdog failure not interrupt only");
    cfg2_wdog_a: assert property (quiet && !ev.ext_reset_low && ev.wdog_fail && !dev_mode
        && fs_config == `SBC_CFG_2 && mode == m_nm |=> mode == m_fs)
        else $error("config 2 watchdog failure missed fail-safe");
    uv_failsafe_a: assert property (ce && ev.mcu_uv_timeout && ev.vs_above_lhuv && mode == m_nm |=> mode == m_fs)
        else $error("supply time-out missed fail-safe");
    failsafe_out_a: assert property (mode == m_fs
        |-> limp_home_output && !regulators_en && !mcu_supply_en && xcvr_wake_capable)
        else $error("fail-safe outputs wrong");
endmodule
bind sbc_mode_ctrl sbc_mode_checker chk_u (.clk, .rst, .ce, .fs_config, .ev, .mcu_reset_output_n,
    .limp_home_output, .mcu_supply_en, .regulators_en, .xcvr_wake_capable, .wdog_int, .dev_mode, .mode);
`default_nettype wire

// file: tb/sbc_mcu_model.sv
// Purpose: microcontroller side: mode commands and status reads
// Assumes: requests change on the falling clock edge
// Notes: a read keeps the status word in seen
`timescale 1ns/100ps
`default_nettype none
module sbc_mcu_model (
    input wire logic clk,
    input wire sbc_pkg::sbc_status_s status,
    output var sbc_pkg::sbc_cmd_s cmd,
    output var logic status_read
);
    sbc_pkg::sbc_status_s seen;
    initial begin
        cmd = '0;
        status_read = 1'b0;
    end
    // one-cycle command pulse
    task automatic send(input sbc_pkg::sbc_cmd_s c);
        sbc_pkg::sbc_cmd_s c1;
        c1 = c;
        c1.valid = 1'b1;
        @(negedge clk);
        cmd = c1;
        @(negedge clk);
        cmd = '0;
    endtask
    // gap lets a previous clear reach the status word
    task automatic read_status();
        repeat (2) @(negedge clk);
        seen = status;
        status_read = 1'b1;
        @(negedge clk);
        status_read = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the mode controller
// Assumes: init time-out shortened to 50 cycles
// Notes: inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defs.svh"
module tb;
    localparam sbc_pkg::sbc_mode_e m_nm = sbc_pkg::SBC_NORMAL;
    localparam sbc_pkg::sbc_mode_e m_rs = sbc_pkg::SBC_RESTART;
    localparam sbc_pkg::sbc_mode_e m_fs = sbc_pkg::SBC_FAILSAFE;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic test_pin_low = 1'b0;
    logic [2:0] fs_config = `SBC_CFG_1;
    logic reset_delay_sel = 1'b0;
    sbc_pkg::sbc_event_s ev = '0;
    logic [3:0] wake_src = 4'h0;
    logic [8:0] fs_ev [2] = '{9'h002, 9'h030};
    sbc_pkg::sbc_cmd_s cmd;
    sbc_pkg::sbc_mode_e mode;
    sbc_pkg::sbc_status_s status;
    logic status_read, rst_n, limp, sup, reg_en, xcvr, wint, dev;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    always #5 clk = ~clk;
    sbc_mode_ctrl #(.INIT_TMO_CYC(50)) dut_u (.clk, .rst, .ce, .test_pin_low, .fs_config,
        .reset_delay_sel, .ev, .cmd, .wake_src, .status_read, .mcu_reset_output_n(rst_n),
        .limp_home_output(limp), .mcu_supply_en(sup), .regulators_en(reg_en), .xcvr_wake_capable(xcvr),
        .wdog_int(wint), .dev_mode(dev), .mode, .status);
    sbc_mcu_model mcu_u (.clk, .status, .cmd, .status_read);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // event bits held for one enabled edge
    task automatic pulse(input logic [8:0] e);
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = '0;
    endtask
    // bounded wait, n counts the falling edges
    task automatic wait_mode(input sbc_pkg::sbc_mode_e m);
        n = 0;
        while (mode !== m && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (mode !== m) begin
            err_count++;
            $display("wrong value at %0t: mode wait ran out", $time);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        // no mode command: time-out restart
        wait_mode(m_rs);
        check(16'({limp, rst_n}), 16'h2);
        wait_mode(m_nm);
        check(16'(n), 16'hc8);
        check(16'(rst_n), 16'h1);
        mcu_u.read_status();
        check(16'(mcu_u.seen.limp_reason_bits), 16'(`SBC_LR_INIT_TMO));
        mcu_u.read_status();
        check(16'(mcu_u.seen.limp_reason_bits), 16'h0);
        $display("test init time-out done");
        // outside reset, limp-home on, long delay
        reset_delay_sel = 1'b1;
        pulse(9'h100);
        check(16'({mode, limp}), 16'({m_rs, 1'b1}));
        wait_mode(m_nm);
        check(16'(n), 16'h3e8);
        mcu_u.read_status();
        check(16'(mcu_u.seen.restart_reason_bits), 16'(`SBC_RR_EXT));
        $display("test outside reset done");
        // sleep, then a wake with a source code
        mcu_u.send(8'h02);
        mcu_u.send(8'h20);
        wake_src = 4'ha;
        pulse(9'h001);
        check(16'({sup, limp, wint}), 16'h4);
        wait_mode(m_nm);
        mcu_u.read_status();
        check(16'(mcu_u.seen.wake_source_bits), 16'ha);
        $display("test sleep wake done");
        // config 4: first failure restarts, second enters fail-safe
        fs_config = `SBC_CFG_4;
        pulse(9'h002);
        check(16'({mode, limp}), 16'({m_rs, 1'b0}));
        wait_mode(m_nm);
        mcu_u.read_status();
        check(16'(mcu_u.seen.restart_reason_bits), 16'(`SBC_RR_WDOG_SPI));
        pulse(9'h002);
        check(16'(mode), 16'(m_fs));
        check(16'({limp, sup, reg_en, xcvr}), 16'h9);
        pulse(9'h001);
        check(16'({mode, limp}), 16'({m_rs, 1'b1}));
        wait_mode(m_nm);
        mcu_u.read_status();
        check(16'({mcu_u.seen.limp_reason_bits, mcu_u.seen.from_failsafe}), 16'({`SBC_LR_FS_WAKE, 1'b1}));
        check(16'(mcu_u.seen.wake_source_bits), 16'ha);
        $display("test config 4 done");
        // config 2 watchdog failure and supply time-out
        fs_config = `SBC_CFG_2;
        for (int i = 0; i < 2; i++) begin
            pulse(fs_ev[i]);
            check(16'(mode), 16'(m_fs));
            pulse(9'h001);
            wait_mode(m_nm);
        end
        $display("test fail-safe entries done");
        // config 1 causes with the short delay
        fs_config = `SBC_CFG_1;
        reset_delay_sel = 1'b0;
        mcu_u.send(8'h02);
        pulse(9'h002);
        check(16'({mode, limp}), 16'({m_rs, 1'b1}));
        wait_mode(m_nm);
        mcu_u.read_status();
        check(16'(mcu_u.seen.limp_reason_bits), 16'(`SBC_LR_WDOG));
        mcu_u.send(8'h02);
        pulse(9'h080);
        check(16'({mode, limp}), 16'({m_rs, 1'b1}));
        wait_mode(m_nm);
        mcu_u.read_status();
        check(16'(mcu_u.seen.limp_reason_bits), 16'(`SBC_LR_CLAMP));
        pulse(9'h040);
        check(16'({mode, limp}), 16'({m_rs, 1'b1}));
        wait_mode(m_nm);
        mcu_u.read_status();
        check(16'(mcu_u.seen.restart_reason_bits), 16'(`SBC_RR_UV));
        mcu_u.send(8'h10);
        mcu_u.send(8'h08);
        check(16'({mode, limp}), 16'({m_rs, 1'b1}));
        wait_mode(m_nm);
        mcu_u.read_status();
        check(16'(mcu_u.seen.restart_reason_bits), 16'(`SBC_RR_WDOG_SPI));
        $display("test restart causes done");
        // overtemperature latch ignores wakes until cooled
        pulse(9'h008);
        pulse(9'h001);
        check(16'(mode), 16'(m_fs));
        pulse(9'h004);
        check(16'(mode), 16'(m_rs));
        wait_mode(m_nm);
        $display("test overtemperature done");
        // development mode after a grounded test pin
        rst = 1'b1;
        test_pin_low = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        mcu_u.send(8'h80);
        check(16'({dev, rst_n}), 16'h3);
        pulse(9'h002);
        check(16'({wint, rst_n, mode}), 16'({2'h3, m_nm}));
        pulse(9'h100);
        check(16'(mode), 16'(m_rs));
        // clock enable low: restart timer and outputs frozen
        ce = 1'b0;
        repeat (20) @(negedge clk);
        check(16'({mode, rst_n}), 16'({m_rs, 1'b0}));
        ce = 1'b1;
        wait_mode(m_nm);
        check(16'(n), 16'hc8);
        $display("test development mode done");
        finish_test();
    end
endmodule
`default_nettype wire
